/* File: design/ieb_top.sv */
`timescale 1ns/100ps
module ieb_top
	import ieb_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Request flags from the sources, one 16-bit word per enable word
	input wire logic [79:0] src_flag,
	// Gated requests to arbitration
	output logic [79:0] req_out,
	// Summary interrupt
	output logic irq
);

	// ==========================================
	// Address decode
	logic sel_en;
	logic sel_flag;
	logic sel_prio;
	logic sel_status;
	always_comb
	begin
		sel_en = reg_addr <= ADDR_EN_FIVE;
		sel_flag = (reg_addr >= ADDR_FLAG_BASE) && (reg_addr < ADDR_PRIO_BASE);
		sel_prio = (reg_addr >= ADDR_PRIO_BASE) && (reg_addr < ADDR_IRQ_STATUS);
		sel_status = reg_addr == ADDR_IRQ_STATUS;
	end

	// ==========================================
	// Enable words
	localparam logic [79:0] EN_MASK = {
		MASK_EN_FIVE,
		MASK_EN_FOUR,
		MASK_EN_THREE,
		MASK_EN_TWO,
		MASK_EN_ONE
	};

	logic [79:0] en;
	logic [79:0] next_en;

	always_comb
	begin
		next_en = en;
		if (reg_wr && sel_en)
		begin
			next_en[reg_addr[2:0]*16 +: 16] = reg_wdata & EN_MASK[reg_addr[2:0]*16 +: 16];
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			en <= {NUM_WORDS{RESET_EN}};
		else
			en <= next_en;
	end

	// ==========================================
	// Word one fields
	logic twowire_a_master_en;
	logic twowire_a_slave_en;
	assign twowire_a_master_en = en[1];
	assign twowire_a_slave_en = en[0];

	// ==========================================
	// Word two fields
	logic parallel_port_en;
	logic compare_ch8_en;
	logic compare_ch7_en;
	logic compare_ch6_en;
	logic compare_ch5_en;
	logic capture_ch6_en;
	logic capture_ch5_en;
	logic capture_ch4_en;
	logic capture_ch3_en;
	logic serial_periph_b_event_en;
	logic serial_periph_b_fault_en;
	assign parallel_port_en = en[16+13];
	assign compare_ch8_en = en[16+12];
	assign compare_ch7_en = en[16+11];
	assign compare_ch6_en = en[16+10];
	assign compare_ch5_en = en[16+9];
	assign capture_ch6_en = en[16+8];
	assign capture_ch5_en = en[16+7];
	assign capture_ch4_en = en[16+6];
	assign capture_ch3_en = en[16+5];
	assign serial_periph_b_event_en = en[16+1];
	assign serial_periph_b_fault_en = en[16+0];

	// ==========================================
	// Word three fields
	logic calendar_clock_en;
	logic ext_pin_irq4_en;
	logic ext_pin_irq3_en;
	logic twowire_b_master_en;
	logic twowire_b_slave_en;
	assign calendar_clock_en = en[32+14];
	assign ext_pin_irq4_en = en[32+6];
	assign ext_pin_irq3_en = en[32+5];
	assign twowire_b_master_en = en[32+2];
	assign twowire_b_slave_en = en[32+1];

	// ==========================================
	// Word four fields
	logic charge_time_unit_en;
	logic low_voltage_detect_en;
	logic checksum_gen_en;
	logic serial_port_b_error_en;
	logic serial_port_a_error_en;
	assign charge_time_unit_en = en[48+13];
	assign low_voltage_detect_en = en[48+8];
	assign checksum_gen_en = en[48+3];
	assign serial_port_b_error_en = en[48+2];
	assign serial_port_a_error_en = en[48+1];

	// ==========================================
	// Word five fields
	logic capture_ch9_en;
	logic compare_ch9_en;
	logic serial_periph_c_event_en;
	logic serial_periph_c_fault_en;
	logic serial_port_d_tx_en;
	logic serial_port_d_rx_en;
	logic serial_port_d_error_en;
	logic twowire_c_master_en;
	logic twowire_c_slave_en;
	logic serial_port_c_tx_en;
	logic serial_port_c_rx_en;
	logic serial_port_c_error_en;
	assign capture_ch9_en = en[64+13];
	assign compare_ch9_en = en[64+12];
	assign serial_periph_c_event_en = en[64+11];
	assign serial_periph_c_fault_en = en[64+10];
	assign serial_port_d_tx_en = en[64+9];
	assign serial_port_d_rx_en = en[64+8];
	assign serial_port_d_error_en = en[64+7];
	assign twowire_c_master_en = en[64+5];
	assign twowire_c_slave_en = en[64+4];
	assign serial_port_c_tx_en = en[64+3];
	assign serial_port_c_rx_en = en[64+2];
	assign serial_port_c_error_en = en[64+1];

	// ==========================================
	// Gate enables rebuilt from the named fields, unimplemented positions held at zero
	logic [79:0] en_view;
	assign en_view[15:0] = {
		14'h0000,
		twowire_a_master_en,
		twowire_a_slave_en
	};
	assign en_view[31:16] = {
		2'h0,
		parallel_port_en,
		compare_ch8_en,
		compare_ch7_en,
		compare_ch6_en,
		compare_ch5_en,
		capture_ch6_en,
		capture_ch5_en,
		capture_ch4_en,
		capture_ch3_en,
		3'h0,
		serial_periph_b_event_en,
		serial_periph_b_fault_en
	};
	assign en_view[47:32] = {
		1'h0,
		calendar_clock_en,
		7'h00,
		ext_pin_irq4_en,
		ext_pin_irq3_en,
		2'h0,
		twowire_b_master_en,
		twowire_b_slave_en,
		1'h0
	};
	assign en_view[63:48] = {
		2'h0,
		charge_time_unit_en,
		4'h0,
		low_voltage_detect_en,
		4'h0,
		checksum_gen_en,
		serial_port_b_error_en,
		serial_port_a_error_en,
		1'h0
	};
	assign en_view[79:64] = {
		2'h0,
		capture_ch9_en,
		compare_ch9_en,
		serial_periph_c_event_en,
		serial_periph_c_fault_en,
		serial_port_d_tx_en,
		serial_port_d_rx_en,
		serial_port_d_error_en,
		1'h0,
		twowire_c_master_en,
		twowire_c_slave_en,
		serial_port_c_tx_en,
		serial_port_c_rx_en,
		serial_port_c_error_en,
		1'h0
	};

	// ==========================================
	// Priority fields, one per source
	logic [2:0] prio [80];
	logic [2:0] next_prio [80];
	logic [3:0] prio_idx;

	always_comb
	begin
		prio_idx = reg_addr - ADDR_PRIO_BASE;
		next_prio = prio;
		if (reg_wr && sel_prio)
		begin
			for (int i = 0; i < 16; i++)
				next_prio[prio_idx[2:0]*16 + i] = reg_wdata[i] ? 3'h7 : PRIO_OFF;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			prio <= '{default: PRIO_RESET};
		else
			prio <= next_prio;
	end

	// ==========================================
	// Gates
	logic [79:0] pass;
	genvar g;
	generate
		for (g = 0; g < 80; g++)
		begin : gen_gate
			ieb_gate u_gate (
				.flag(src_flag[g] & EN_MASK[g]),
				.enable(en_view[g]),
				.prio(prio[g]),
				.pass(pass[g])
			);
		end
	endgenerate

	// ==========================================
	// Per-word summaries for the interrupt and read paths
	logic [NUM_WORDS-1:0] word_pending;
	logic [15:0] flag_word [NUM_WORDS];
	logic [15:0] en_word [NUM_WORDS];
	generate
		for (g = 0; g < NUM_WORDS; g++)
		begin : gen_word
			assign word_pending[g] = |pass[g*16 +: 16];
			assign flag_word[g] = src_flag[g*16 +: 16] & EN_MASK[g*16 +: 16];
			assign en_word[g] = en[g*16 +: 16];
		end
	endgenerate

	// ==========================================
	// Sticky interrupt status: set wins over write-one clear
	logic irq_sticky;
	logic next_irq_sticky;
	always_comb
	begin
		next_irq_sticky = irq_sticky;
		if (reg_wr && sel_status && reg_wdata[0])
			next_irq_sticky = 1'b0;
		if (|word_pending)
			next_irq_sticky = 1'b1;
	end

	logic irq_mask;
	logic next_irq_mask;
	always_comb
	begin
		next_irq_mask = irq_mask;
		if (reg_wr && sel_status)
			next_irq_mask = reg_wdata[8];
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			req_out <= '0;
			irq_sticky <= 1'b0;
			irq_mask <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			req_out <= pass;
			irq_sticky <= next_irq_sticky;
			irq_mask <= next_irq_mask;
			irq <= next_irq_sticky & next_irq_mask;
		end
	end

	// ==========================================
	// Read path
	logic [15:0] next_rdata;
	logic [3:0] flag_idx;
	logic [3:0] prio_rd_idx;
	logic [2:0] flag_sel;
	logic [2:0] prio_sel;
	logic [15:0] prio_word;
	always_comb
	begin
		flag_idx = reg_addr - ADDR_FLAG_BASE;
		prio_rd_idx = reg_addr - ADDR_PRIO_BASE;
		flag_sel = 3'h0;
		prio_sel = 3'h0;
		if (sel_flag)
			flag_sel = flag_idx[2:0];
		if (sel_prio)
			prio_sel = prio_rd_idx[2:0];
		prio_word = '0;
		for (int i = 0; i < 16; i++)
			prio_word[i] = prio[prio_sel*16 + i] != PRIO_OFF;
		next_rdata = '0;
		if (reg_rd)
		begin
			if (sel_en)
				next_rdata = en_word[reg_addr[2:0]];
			else if (sel_flag)
				next_rdata = flag_word[flag_sel];
			else if (sel_prio)
				next_rdata = prio_word;
			else
				next_rdata = {7'h00, irq_mask, 7'h00, irq_sticky};
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			reg_rdata <= '0;
		else
			reg_rdata <= next_rdata;
	end

endmodule

/* File: design/ieb_pkg.sv */
package ieb_pkg;

	// ==========================================
	// Register map (word indices on the register port)
	localparam logic [3:0] ADDR_EN_ONE = 4'h0;
	localparam logic [3:0] ADDR_EN_TWO = 4'h1;
	localparam logic [3:0] ADDR_EN_THREE = 4'h2;
	localparam logic [3:0] ADDR_EN_FOUR = 4'h3;
	localparam logic [3:0] ADDR_EN_FIVE = 4'h4;
	localparam logic [3:0] ADDR_FLAG_BASE = 4'h5;
	localparam logic [3:0] ADDR_PRIO_BASE = 4'ha;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'hf;
	localparam int NUM_WORDS = 5;

	// ==========================================
	// Implemented enable bits per word
	localparam logic [15:0] MASK_EN_ONE = 16'h0003;
	localparam logic [15:0] MASK_EN_TWO = 16'h3fe3;
	localparam logic [15:0] MASK_EN_THREE = 16'h4066;
	localparam logic [15:0] MASK_EN_FOUR = 16'h210e;
	localparam logic [15:0] MASK_EN_FIVE = 16'h3fbe;
	localparam logic [15:0] RESET_EN = 16'h0000;

	// ==========================================
	// Priority field codes
	localparam logic [2:0] PRIO_OFF = 3'h0;
	localparam logic [2:0] PRIO_RESET = 3'h4;

	typedef enum logic [1:0] {
		IEB_IDLE = 2'b01,
		IEB_READ = 2'b10
	} ieb_rd_state_t;

endpackage

/* File: design/ieb_gate.sv */
`timescale 1ns/100ps
// One source: flag, enable and priority gate
module ieb_gate
	import ieb_pkg::*;
(
	input wire logic flag,
	input wire logic enable,
	input wire logic [2:0] prio,
	output logic pass
);

	always_comb
	begin
		pass = flag & enable & (prio != PRIO_OFF);
	end

endmodule

/* File: tb/ieb_src_model.sv */
`timescale 1ns/100ps
// ==========
// Request sources
module ieb_src_model
(
	// Clock and stimulus
	input wire logic sys_clk,
	input wire logic [79:0] raise,
	// Level flags
	output logic [79:0] src_flag
);
	// Every source, external pins included, is taken as routed to a pin
	always_ff @(posedge sys_clk)
		src_flag <= raise;
endmodule

/* File: tb/ieb_top_sva.sv */
`timescale 1ns/100ps
// ==========
// Port checker
module ieb_top_sva
	import ieb_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// Requests
	input wire logic [79:0] src_flag,
	input wire logic [79:0] req_out,
	input wire logic irq
);
	localparam logic [79:0] M_ALL = {MASK_EN_FIVE, MASK_EN_FOUR, MASK_EN_THREE, MASK_EN_TWO, MASK_EN_ONE};
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("rdata not idle");
	a_req_gated: assert property ((req_out & ~$past(src_flag)) == 80'h0)
		else $error("req without flag");
	a_unused_req: assert property ((req_out & ~M_ALL) == 80'h0)
		else $error("req on unused bit");
	a_unused_rd: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_EN_THREE |-> (reg_rdata & ~MASK_EN_THREE) == 16'h0)
		else $error("unused bit read high");
	a_reset_clear: assert property ($rose(rst_n) |-> req_out == 80'h0 && !irq)
		else $error("not clear after reset");
	a_en_block: assert property (reg_wr && reg_addr == ADDR_EN_TWO && reg_wdata == 16'h0 ##1 !reg_wr |=> req_out[31:16] == 16'h0)
		else $error("disabled source passed");
	a_prio_off: assert property (reg_wr && reg_addr == ADDR_PRIO_BASE + 4'h1 && reg_wdata == 16'h0 ##1 !reg_wr |=> req_out[31:16] == 16'h0)
		else $error("priority zero passed");
	a_read_back: assert property (reg_wr && reg_addr == ADDR_EN_FIVE ##1 !reg_wr ##1 reg_rd && reg_addr == ADDR_EN_FIVE |=> reg_rdata == ($past(reg_wdata, 3) & MASK_EN_FIVE))
		else $error("readback wrong");
	a_mask_off: assert property (reg_wr && reg_addr == ADDR_IRQ_STATUS && !reg_wdata[8] |=> ##1 !irq)
		else $error("irq while masked");
	c_irq: cover property (irq);
	c_req: cover property (|req_out);
	c_prio: cover property (reg_wr && reg_addr == ADDR_PRIO_BASE + 4'h1);
endmodule
bind ieb_top ieb_top_sva i_sva(.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_flag(src_flag), .req_out(req_out), .irq(irq));

/* File: tb/ieb_top_test.sv */
`timescale 1ns/100ps
// ==========
// Register-level bench
module ieb_top_test
	import ieb_pkg::*;
;
	logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, irq;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata;
	logic [79:0] raise = '0, src_flag, req_out, all_m, no_two;
	logic [15:0] msk [5] = '{MASK_EN_ONE, MASK_EN_TWO, MASK_EN_THREE, MASK_EN_FOUR, MASK_EN_FIVE};
	int bad_count = 0, tests_run = 0;
	assign all_m = {msk[4], msk[3], msk[2], msk[1], msk[0]};
	assign no_two = all_m & ~(80'hffff << 16);
	ieb_src_model i_src(.sys_clk(sys_clk), .raise(raise), .src_flag(src_flag));
	ieb_top i_dut(.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_flag(src_flag), .req_out(req_out), .irq(irq));
	initial forever #50 sys_clk = ~sys_clk;
	task automatic chk_val(input logic [79:0] got, input logic [79:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk_val(reg_rdata, exp);
	endtask
	task automatic settle;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask
	task automatic final_report;
		$display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		#100000 bad_count++;
		final_report;
	end
	initial
	begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < NUM_WORDS; i++)
			rd(ADDR_EN_ONE + 4'(i), RESET_EN);
		$display("test reset done");
		@(posedge sys_clk);
		raise <= '1;
		for (int i = 0; i < NUM_WORDS; i++)
		begin
			wr(ADDR_EN_ONE + 4'(i), 16'hffff);
			rd(ADDR_EN_ONE + 4'(i), msk[i]);
		end
		settle;
		chk_val(req_out, all_m);
		wr(ADDR_EN_TWO, 16'h0000);
		settle;
		chk_val(req_out, no_two);
		wr(ADDR_EN_TWO, 16'hffff);
		wr(ADDR_PRIO_BASE + 4'h1, 16'h0000);
		settle;
		chk_val(req_out, no_two);
		rd(ADDR_PRIO_BASE + 4'h1, 16'h0000);
		wr(ADDR_PRIO_BASE + 4'h1, 16'hffff);
		settle;
		chk_val(req_out, all_m);
		rd(ADDR_PRIO_BASE + 4'h1, 16'hffff);
		rd(ADDR_FLAG_BASE + 4'h2, MASK_EN_THREE);
		$display("test gating done");
		wr(ADDR_IRQ_STATUS, 16'h0100);
		settle;
		chk_val({79'h0, irq}, 80'h1);
		rd(ADDR_IRQ_STATUS, 16'h0101);
		@(posedge sys_clk);
		raise <= '0;
		settle;
		wr(ADDR_IRQ_STATUS, 16'h0101);
		settle;
		chk_val({79'h0, irq}, 80'h0);
		wr(ADDR_IRQ_STATUS, 16'h0000);
		$display("test irq done");
		@(posedge sys_clk);
		raise <= '1;
		rst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(ADDR_EN_FIVE, RESET_EN);
		settle;
		chk_val(req_out, 80'h0);
		chk_val({79'h0, irq}, 80'h0);
		$display("test reset again done");
		final_report;
	end
endmodule
